// *** rtl/pmcs_pkg.sv ***
/*
  Constants and carrier types for the pixel and media clock select block.
  Assumes a single 20 MHz system clock and byte-wide registers, each on its
  own 32-bit word of an Avalon-MM slave; the byte address is four times the
  register index.
*/
// What this block does
// R1: Flat-panel pixel source from two-bit field.
// R2: Flat-panel pixel divide 1:1 to 4:1, bits 5-4.
// R3: Software sets flicker enable for filtered TV.
// R4: CRT/TV pixel divide 1:1 to 4:1, bits 5-4.
// R5: CRT/TV pixel source from bits 1-0.
// R6: Media-port clock divide 1:1 to 4:1.
// R7: Media-port clock source from two-bit field.
// R8: Memory clock source is the divided memory clock.
// R9: Wait-state field steers host-to-memory handshake.
// R10: Host-interface clock full or half, strap-selected.
// R11: Software picks wait setting meeting period limits.
// R12: Software never writes reserved wait code 11.
// R13: Unused bits read zero, writes ignored.
package pmcs_pkg;

  // Register indices; the bus address is the index times four.
  localparam logic [7:0] IDX_STATUS   = 8'h0C;
  localparam logic [7:0] IDX_MEM_CLK  = 8'h10;
  localparam logic [7:0] IDX_FP_CLK   = 8'h14;
  localparam logic [7:0] IDX_CRT_CLK  = 8'h18;
  localparam logic [7:0] IDX_MP_CLK   = 8'h1C;
  localparam logic [7:0] IDX_WAIT_SEL = 8'h1E;

  // Field positions inside the byte registers.
  localparam int SRC_LSB     = 0;
  localparam int DIV_LSB     = 4;
  localparam int FLICKER_BIT = 7;
  localparam int MEM_DIV_BIT = 4;
  localparam int WAIT_LSB    = 0;
  localparam int STRAP_BIT   = 0;

  // Reset values of the writable registers.
  localparam logic [7:0] RST_MEM_CLK  = 8'h00;
  localparam logic [7:0] RST_PIX_CLK  = 8'h00;
  localparam logic [7:0] RST_WAIT_SEL = 8'h00;

  // Timing figures: system clock period and the host/memory margin.
  localparam int CLK_PERIOD_NS   = 50;
  localparam int WAIT_MARGIN_NS  = 4;

  // Source select codes shared by every pixel and media clock.
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_HOSTBUS = 2'h1;
  localparam logic [1:0] SRC_AUX     = 2'h2;
  localparam logic [1:0] SRC_MEMORY  = 2'h3;

  // Memory clock source codes.
  localparam logic [1:0] MSRC_PRIMARY = 2'h0;
  localparam logic [1:0] MSRC_HOSTBUS = 2'h1;
  localparam logic [1:0] MSRC_AUX3    = 2'h2;

  // One pixel or media clock configuration byte.
  typedef struct packed {
    logic       flicker_en;
    logic       unused6;
    logic [1:0] div;
    logic [1:0] unused3_2;
    logic [1:0] src;
  } pmcs_clk_cfg_s;

  // Bus handshake states, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } pmcs_bus_e;

endpackage : pmcs_pkg

// *** rtl/pmcs_clock_select.sv ***
/*
  Pixel, media-port, memory and host-interface clock selection and division.
  Assumes the four clock pins are slow against the 20 MHz system clock, so
  each is sampled through two flip-flops and divided as a sampled level; the
  outputs are registered clock levels, not glitch-free silicon clock muxes.
*/
`timescale 1ns/1ns
module pmcs_clock_select
  import pmcs_pkg::*;
(
  input  wire logic        clock,                  // System clock, 20 MHz.
  input  wire logic        rst_b,                  // Synchronous reset, active low.
  input  wire logic        clk_en,                 // Freezes all state while low.
  input  wire logic        primary_clock_input,    // Clock pin, asynchronous.
  input  wire logic        host_bus_clock,         // Host bus clock pin.
  input  wire logic        second_aux_clock_input, // Second auxiliary clock pin.
  input  wire logic        third_aux_clock_input,  // Third auxiliary clock pin.
  input  wire logic        host_clock_halving_strap, // Strap caught at reset.
  input  wire logic [7:0]  address,                // Avalon byte address.
  input  wire logic        read,                   // Avalon read request.
  input  wire logic        write,                  // Avalon write request.
  input  wire logic [31:0] writedata,              // Avalon write data.
  input  wire logic [3:0]  byteenable,             // Avalon byte lanes.
  output logic      [31:0] readdata,               // Avalon read data.
  output logic             waitrequest,            // Avalon wait request.
  output logic             memory_clock,           // Divided memory clock level.
  output logic             flat_panel_pixel_clock, // Flat-panel pixel clock.
  output logic             crt_tv_pixel_clock,     // CRT/TV pixel clock.
  output logic             media_port_clock,       // Media-port clock.
  output logic             flicker_filter_clock,   // Gated flicker-filter clock.
  output logic             host_interface_clock,   // Host bus clock or half of it.
  output logic      [1:0]  host_memory_wait_states // Wait code to memory path.
);

  // Divider slots: 0 memory, 1 flat panel, 2 CRT/TV, 3 media port, 4 host.
  localparam int NDIV = 5;

  // Next count of a divide-by-(n+1) counter on a source rising edge.
  function automatic logic [1:0] div_count(input logic [1:0] cnt,
                                           input logic [1:0] n,
                                           input logic       rise);
    if (!rise) begin
      div_count = cnt;
    end else if (cnt >= n) begin
      div_count = 2'h0;
    end else begin
      div_count = cnt + 2'h1;
    end
  endfunction : div_count

  // Output level: follow the source at 1:1, else high for the first half of the count, rounded up.
  function automatic logic div_level(input logic [1:0] cnt,
                                     input logic [1:0] n,
                                     input logic       lvl);
    logic [2:0] half;
    half = 3'({1'b0, n} + 3'h2) >> 1;
    if (n == 2'h0) begin
      div_level = lvl;
    end else begin
      div_level = ({1'b0, cnt} < half);
    end
  endfunction : div_level

  // Pin synchronisers: stage 1 feeds only stage 2; edges use divider history.
  logic [3:0] sync1_q, sync2_q;
  logic [3:0] sync1_d, sync2_d;
  logic       strap_sync1_q, strap_sync2_q, strap_q;
  logic       strap_sync1_d, strap_sync2_d, strap_d;

  // Configuration registers and bus state.
  logic [7:0]    mem_cfg_q, mem_cfg_d;
  pmcs_clk_cfg_s fp_cfg_q, fp_cfg_d;
  pmcs_clk_cfg_s crt_cfg_q, crt_cfg_d;
  pmcs_clk_cfg_s mp_cfg_q, mp_cfg_d;
  logic [1:0]    wait_q, wait_d;
  pmcs_bus_e     bus_q, bus_d;
  logic [31:0]   rdata_q, rdata_d;

  // Divider state.
  logic [1:0]      cnt_q [NDIV];
  logic [1:0]      cnt_d [NDIV];
  logic [NDIV-1:0] out_q, out_d, prev_q, prev_d;
  logic [NDIV-1:0] src_lvl, src_rise;
  logic [1:0]      ratio [NDIV];

  logic       bus_req, wr_fire;
  logic [7:0] reg_idx;
  logic [7:0] rd_byte;

  assign bus_req = read | write;
  assign reg_idx = {2'h0, address[7:2]};
  assign wr_fire = write && (bus_q == BUS_ACK) && byteenable[0];

  // Pins are captured twice; the strap is caught while reset is held.
  always_comb begin
    sync1_d       = {third_aux_clock_input, second_aux_clock_input,
                     host_bus_clock, primary_clock_input};
    sync2_d       = sync1_q;
    strap_sync1_d = host_clock_halving_strap;
    strap_sync2_d = strap_sync1_q;
    strap_d       = rst_b ? strap_q : strap_sync2_q; // [R10]
  end

  always_ff @(posedge clock) begin
    if (clk_en) begin
      sync1_q       <= sync1_d;
      sync2_q       <= sync2_d;
      strap_sync1_q <= strap_sync1_d;
      strap_sync2_q <= strap_sync2_d;
      strap_q       <= strap_d;
    end
  end

  // Source levels per slot; a pixel or media source code of 11 takes the divided memory clock.
  function automatic logic pick(input logic [1:0] sel, input logic [3:0] pins,
                                input logic mem);
    case (sel)
      SRC_PRIMARY: pick = pins[0];
      SRC_HOSTBUS: pick = pins[1];
      SRC_AUX:     pick = pins[2];
      default:     pick = mem;
    endcase
  endfunction : pick

  always_comb begin
    case (mem_cfg_q[1:0]) // [R8]
      MSRC_PRIMARY: src_lvl[0] = sync2_q[0];
      MSRC_HOSTBUS: src_lvl[0] = sync2_q[1];
      MSRC_AUX3:    src_lvl[0] = sync2_q[3];
      default:      src_lvl[0] = 1'b0; // Reserved code stops the memory clock.
    endcase
    src_lvl[1] = pick(fp_cfg_q.src, sync2_q, out_q[0]);  // [R1] [R8]
    src_lvl[2] = pick(crt_cfg_q.src, sync2_q, out_q[0]); // [R5] [R8]
    src_lvl[3] = pick(mp_cfg_q.src, sync2_q, out_q[0]);  // [R7] [R8]
    src_lvl[4] = sync2_q[1];
    ratio[0]   = {1'b0, mem_cfg_q[MEM_DIV_BIT]};
    ratio[1]   = fp_cfg_q.div;  // [R2]
    ratio[2]   = crt_cfg_q.div; // [R4]
    ratio[3]   = mp_cfg_q.div;  // [R6]
    ratio[4]   = {1'b0, strap_q}; // [R10]
  end

  // Edges are taken from stage 2 of the pins, never from stage 1.
  always_comb begin
    for (int i = 0; i < NDIV; i++) begin
      src_rise[i] = src_lvl[i] & ~prev_q[i];
      cnt_d[i]    = div_count(cnt_q[i], ratio[i], src_rise[i]);
      out_d[i]    = div_level(cnt_d[i], ratio[i], src_lvl[i]);
    end
    prev_d = src_lvl;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < NDIV; i++) begin
        cnt_q[i] <= 2'h0;
      end
      out_q  <= '0;
      prev_q <= '0;
    end else if (clk_en) begin
      cnt_q  <= cnt_d;
      out_q  <= out_d;
      prev_q <= prev_d;
    end
  end

  assign memory_clock            = out_q[0];
  assign flat_panel_pixel_clock  = out_q[1];
  assign crt_tv_pixel_clock      = out_q[2];
  assign media_port_clock        = out_q[3];
  assign host_interface_clock    = out_q[4];
  // Software owns the enable; the gate only passes the CRT/TV clock. [R3]
  assign flicker_filter_clock    = out_q[2] & crt_cfg_q.flicker_en;
  // Code 11 is passed as written; software is trusted to avoid it. [R9] [R12]
  assign host_memory_wait_states = wait_q;

  // Read mux; only defined fields reach the bus, the rest reads zero.
  always_comb begin
    case (reg_idx)
      IDX_STATUS:   rd_byte = {7'h00, strap_q};
      IDX_MEM_CLK:  rd_byte = mem_cfg_q & 8'h13;         // [R13]
      IDX_FP_CLK:   rd_byte = 8'(fp_cfg_q) & 8'h33;      // [R13]
      IDX_CRT_CLK:  rd_byte = 8'(crt_cfg_q) & 8'hB3;     // [R13]
      IDX_MP_CLK:   rd_byte = 8'(mp_cfg_q) & 8'h33;      // [R13]
      IDX_WAIT_SEL: rd_byte = {6'h00, wait_q};           // [R13]
      default:      rd_byte = 8'h00;
    endcase
  end

  // Every request waits one cycle, so read data is a flop, not a mux path.
  always_comb begin
    bus_d     = bus_q;
    rdata_d   = rdata_q;
    mem_cfg_d = mem_cfg_q;
    fp_cfg_d  = fp_cfg_q;
    crt_cfg_d = crt_cfg_q;
    mp_cfg_d  = mp_cfg_q;
    wait_d    = wait_q;
    case (bus_q)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_d   = BUS_ACK;
          rdata_d = {24'h000000, rd_byte};
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
    if (wr_fire) begin
      case (reg_idx)
        IDX_MEM_CLK:  mem_cfg_d = writedata[7:0] & 8'h13;                   // [R13]
        IDX_FP_CLK:   fp_cfg_d  = pmcs_clk_cfg_s'(writedata[7:0] & 8'h33);  // [R13]
        IDX_CRT_CLK:  crt_cfg_d = pmcs_clk_cfg_s'(writedata[7:0] & 8'hB3);  // [R13]
        IDX_MP_CLK:   mp_cfg_d  = pmcs_clk_cfg_s'(writedata[7:0] & 8'h33);  // [R13]
        IDX_WAIT_SEL: wait_d    = writedata[WAIT_LSB +: 2];                 // [R9]
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bus_q     <= BUS_IDLE;
      rdata_q   <= 32'h00000000;
      mem_cfg_q <= RST_MEM_CLK;
      fp_cfg_q  <= pmcs_clk_cfg_s'(RST_PIX_CLK);
      crt_cfg_q <= pmcs_clk_cfg_s'(RST_PIX_CLK);
      mp_cfg_q  <= pmcs_clk_cfg_s'(RST_PIX_CLK);
      wait_q    <= RST_WAIT_SEL[1:0];
    end else if (clk_en) begin
      bus_q     <= bus_d;
      rdata_q   <= rdata_d;
      mem_cfg_q <= mem_cfg_d;
      fp_cfg_q  <= fp_cfg_d;
      crt_cfg_q <= crt_cfg_d;
      mp_cfg_q  <= mp_cfg_d;
      wait_q    <= wait_d;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = bus_req & (bus_q != BUS_ACK);

  // Checks on the divider and register behaviour.
  // The edge that ends reset still clears the outputs, so checks that compare
  // an output against a pin also ask for reset high in their antecedent.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_fp_src_primary: assert property ( // [R1]
    rst_b && clk_en && fp_cfg_q.src == SRC_PRIMARY && fp_cfg_q.div == 2'h0
    |=> flat_panel_pixel_clock == $past(sync2_q[0]))
    else $error("flat-panel clock does not follow primary input");
  a_fp_div_four: assert property ( // [R2]
    clk_en && fp_cfg_q.div == 2'h3 && src_rise[1] && cnt_q[1] == 2'h3
    |=> cnt_q[1] == 2'h0 && flat_panel_pixel_clock)
    else $error("flat-panel divide by four wraps wrong");
  a_crt_div_two: assert property ( // [R4]
    clk_en && crt_cfg_q.div == 2'h1 && src_rise[2] && $stable(crt_cfg_q)
    |=> crt_tv_pixel_clock != $past(crt_tv_pixel_clock))
    else $error("CRT/TV divide by two does not toggle");
  a_crt_src_mem: assert property ( // [R5]
    clk_en && crt_cfg_q.src == SRC_MEMORY |-> src_lvl[2] == memory_clock)
    else $error("CRT/TV source is not the memory clock");
  a_mp_div_three: assert property ( // [R6]
    clk_en && mp_cfg_q.div == 2'h2 && !src_rise[3] && $stable(mp_cfg_q)
    |=> $stable(media_port_clock))
    else $error("media-port clock moved without a source edge");
  a_mp_src_aux: assert property ( // [R7]
    clk_en && mp_cfg_q.src == SRC_AUX |-> src_lvl[3] == sync2_q[2])
    else $error("media-port source is not the second auxiliary input");
  a_mem_halved: assert property ( // [R8]
    clk_en && mem_cfg_q[MEM_DIV_BIT] && !src_rise[0] && $stable(mem_cfg_q)
    |=> $stable(memory_clock))
    else $error("halved memory clock moved without a source edge");
  a_wait_written: assert property ( // [R9]
    clk_en && wr_fire && reg_idx == IDX_WAIT_SEL
    |=> host_memory_wait_states == $past(writedata[1:0]))
    else $error("wait code not taken from write");
  a_host_full: assert property ( // [R10]
    rst_b && clk_en && !strap_q |=> host_interface_clock == $past(sync2_q[1]))
    else $error("host-interface clock not at full host rate");
  a_unused_zero: assert property ( // [R13]
    clk_en && bus_q == BUS_IDLE && read && reg_idx == IDX_CRT_CLK
    |=> readdata[6] == 1'b0 && readdata[3:2] == 2'h0 && readdata[31:8] == 24'h0)
    else $error("unused bits read nonzero");
  a_bus_one_wait: assert property (
    clk_en && bus_q == BUS_IDLE && bus_req |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  c_flicker_on: cover property (flicker_filter_clock);
  c_fp_from_mem: cover property (fp_cfg_q.src == SRC_MEMORY && src_rise[1]);
  c_host_halved: cover property (strap_q && src_rise[4]);
  c_wait_set: cover property (wr_fire && reg_idx == IDX_WAIT_SEL);
  c_mem_halved: cover property (mem_cfg_q[MEM_DIV_BIT] && src_rise[0]);

endmodule : pmcs_clock_select

// *** testbench/tb.sv ***
/*
  Self-checking bench for the pixel and media clock select block.
  Assumes an Avalon-MM slave with waitrequest, answering when it will, and that
  clock outputs are registered levels that follow slow, bench-made pins.
*/
`timescale 1ns/1ns
module tb;
  import pmcs_pkg::*;

  logic        clock, rst_b, clk_en, primary_clock_input, host_bus_clock;
  logic        second_aux_clock_input, third_aux_clock_input, host_clock_halving_strap;
  logic [7:0]  address;
  logic        read, write;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        waitrequest, memory_clock, flat_panel_pixel_clock, crt_tv_pixel_clock;
  logic        media_port_clock, flicker_filter_clock, host_interface_clock;
  logic [1:0]  host_memory_wait_states;
  int          mismatches, check_count, cyc, per;
  logic [31:0] rd;
  int          sp[3] = '{16, 24, 32}; // Source periods in system clocks.

  pmcs_clock_select pmcs_clock_select_i (
    .clock                    (clock),
    .rst_b                    (rst_b),
    .clk_en                   (clk_en),
    .primary_clock_input      (primary_clock_input),
    .host_bus_clock           (host_bus_clock),
    .second_aux_clock_input   (second_aux_clock_input),
    .third_aux_clock_input    (third_aux_clock_input),
    .host_clock_halving_strap (host_clock_halving_strap),
    .address                  (address),
    .read                     (read),
    .write                    (write),
    .writedata                (writedata),
    .byteenable               (byteenable),
    .readdata                 (readdata),
    .waitrequest              (waitrequest),
    .memory_clock             (memory_clock),
    .flat_panel_pixel_clock   (flat_panel_pixel_clock),
    .crt_tv_pixel_clock       (crt_tv_pixel_clock),
    .media_port_clock         (media_port_clock),
    .flicker_filter_clock     (flicker_filter_clock),
    .host_interface_clock     (host_interface_clock),
    .host_memory_wait_states  (host_memory_wait_states)
  );

  // Clock at 20 MHz.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Slow pins; each half period is at least eight system clocks so the syncs keep up.
  always @(posedge clock) begin
    cyc                    <= cyc + 1;
    primary_clock_input    <= ((cyc / 8) % 2) == 1;
    host_bus_clock         <= ((cyc / 12) % 2) == 1;
    second_aux_clock_input <= ((cyc / 16) % 2) == 1;
    third_aux_clock_input  <= ((cyc / 20) % 2) == 1;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: period got %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_cnt

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: level got %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  // One bus cycle; the request is held until waitrequest is seen low at an edge.
  task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d,
                           output logic [31:0] q);
    @(posedge clock);
    address   <= a;
    writedata <= {24'h000000, d};
    write     <= wr;
    read      <= ~wr;
    // Ends on waitrequest low; only the bench timeout ends a wait that never sees it.
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q     = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus_cycle

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_cycle(1'b1, a, d, q);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] q);
    bus_cycle(1'b0, a, 8'h00, q);
  endtask : bus_read

  function automatic logic pick(input int k);
    case (k)
      0: pick = flat_panel_pixel_clock;
      1: pick = crt_tv_pixel_clock;
      2: pick = media_port_clock;
      3: pick = memory_clock;
      default: pick = host_interface_clock;
    endcase
  endfunction : pick

  // Counts system clocks up to the next rising level of the chosen output.
  task automatic wait_rise(input int k, output int n);
    logic prev;
    n = 0;
    prev = pick(k);
    forever begin
      @(negedge clock);
      n++;
      if ((prev === 1'b0 && pick(k) === 1'b1) || n >= 600) break;
      prev = pick(k);
    end
  endtask : wait_rise

  // The first two rises let a divider that was mid-count settle.
  task automatic measure(input int k, output int p);
    wait_rise(k, p);
    wait_rise(k, p);
    wait_rise(k, p);
  endtask : measure

  task automatic do_reset(input logic strap);
    @(posedge clock);
    rst_b                    <= 1'b0;
    host_clock_halving_strap <= strap;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
  endtask : do_reset

  // Main sequence.
  initial begin
    {rst_b, read, write, host_clock_halving_strap} = 4'h0;
    {primary_clock_input, host_bus_clock} = 2'h0;
    {second_aux_clock_input, third_aux_clock_input} = 2'h0;
    address = 8'h00; writedata = 32'h00000000; byteenable = 4'h1; clk_en = 1'b1;
    mismatches = 0; check_count = 0; cyc = 0;
    do_reset(1'b0);
    // Reset values, unused bits and an unmapped word.
    for (int k = 0; k < 4; k++) begin
      bus_read(8'h50 + 8'(16 * k) - 8'(k / 3 * 8), rd);
      cmp_reg(rd, 32'h00000000);
    end
    bus_write(8'h60, 8'hFF);
    bus_read(8'h60, rd);
    cmp_reg(rd, 32'h000000B3);
    bus_write(8'h70, 8'hFF);
    bus_read(8'h70, rd);
    cmp_reg(rd, 32'h00000033);
    bus_write(8'h78, 8'hFD);
    bus_read(8'h78, rd);
    cmp_reg(rd, 32'h00000001);
    bus_write(8'h04, 8'hFF);
    bus_read(8'h04, rd);
    cmp_reg(rd, 32'h00000000);
    // Sources 00 to 10 and every divide on each of the three pixel and media clocks.
    for (int k = 0; k < 3; k++)
      for (int s = 0; s < 3; s++)
        for (int d = 0; d < 4; d++) begin
          bus_write(8'h50 + 8'(16 * k), {2'b00, 2'(d), 2'b00, 2'(s)});
          measure(k, per);
          cmp_cnt(per, sp[s] * (d + 1));
        end
    // Memory clock as a source, after its own halving or source choice.
    bus_write(8'h40, 8'h10);
    bus_write(8'h50, 8'h13);
    measure(0, per);
    cmp_cnt(per, 64);
    bus_write(8'h40, 8'h02);
    bus_write(8'h60, 8'h03);
    measure(1, per);
    cmp_cnt(per, 40);
    bus_write(8'h40, 8'h01);
    bus_write(8'h70, 8'h03);
    measure(2, per);
    cmp_cnt(per, 24);
    // Flicker clock gated by its enable bit.
    bus_write(8'h60, 8'h80);
    repeat (40) begin
      @(negedge clock);
      cmp_bit(flicker_filter_clock, crt_tv_pixel_clock);
    end
    bus_write(8'h60, 8'h00);
    repeat (40) begin
      @(negedge clock);
      cmp_bit(flicker_filter_clock, 1'b0);
    end
    // Memory clock from the host bus pin, halved, runs at twice the host bus period.
    bus_write(8'h40, 8'h11);
    measure(3, per);
    cmp_cnt(per, 48);
    // Every legal wait code is passed out as written; code 11 is never sent.
    for (int w = 0; w < 3; w++) begin
      bus_write(8'h78, 8'(w));
      repeat (2) @(negedge clock);
      cmp_reg({30'h0, host_memory_wait_states}, 32'(w));
    end
    // Strap low: host-interface clock at the host bus rate.
    measure(4, per);
    cmp_cnt(per, 24);
    // Enable low freezes every divider while the pins keep moving.
    @(posedge clock);
    clk_en <= 1'b0;
    @(negedge clock);
    rd = {27'h0, host_interface_clock, memory_clock, media_port_clock,
          crt_tv_pixel_clock, flat_panel_pixel_clock};
    repeat (40) @(negedge clock);
    cmp_reg({27'h0, host_interface_clock, memory_clock, media_port_clock,
             crt_tv_pixel_clock, flat_panel_pixel_clock}, rd);
    @(posedge clock);
    clk_en <= 1'b1;
    // Second reset in mid-run with the strap high halves it.
    do_reset(1'b1);
    bus_read(8'h30, rd);
    cmp_reg(rd, 32'h00000001);
    bus_read(8'h78, rd);
    cmp_reg(rd, 32'h00000000);
    measure(4, per);
    cmp_cnt(per, 48);
    stop_test();
  end
endmodule : tb
